// ===== design/voltage_monitor_status_logic.sv
// digital status path of the ten channel voltage monitor
// assumes comparator trip inputs and config ports are synchronous to clk_sys
// and that the analog side acknowledges self calibration with cal_ack
`timescale 1ns/1ps
module voltage_monitor_status_logic
  import vmon_status_pkg::*;
#(
  parameter int NUM_CHAN = vmon_status_pkg::NUM_CH,
  parameter int GPIO_W   = 9
) (
  input  wire logic                                clk_sys,
  input  wire logic                                rst_n,
  input  vmon_status_pkg::chan_cfg_t [NUM_CHAN-1:0] chan_cfg,
  input  vmon_status_pkg::comp_trip_t [NUM_CHAN-1:0] trip_a,
  input  vmon_status_pkg::comp_trip_t [NUM_CHAN-1:0] trip_b,
  input  wire logic                                cal_ack,
  input  wire logic [GPIO_W-1:0]                   gpio_ctrl_in,
  output logic                                     cal_request,
  output logic                                     calibration_done,
  output logic [NUM_CHAN-1:0]                      link_status_a,
  output logic [NUM_CHAN-1:0]                      link_status_b,
  output logic                                     link_status_valid,
  output logic [GPIO_W-1:0]                        gpio_ctrl_out,
  output logic [NUM_CHAN-1:0]                      i2c_status_a,
  output logic [NUM_CHAN-1:0]                      i2c_status_b,
  output logic [NUM_CHAN-1:0]                      zero_detect,
  output logic [NUM_CHAN*THR_W-1:0]                thr_a_ref,
  output logic [NUM_CHAN*THR_W-1:0]                thr_b_ref,
  output logic                                     channel4_a_status,
  output logic                                     channel9_a_status
);

  import vmon_status_pkg::*;

  localparam logic [CNT_W-1:0] ON_CYC  = CNT_W'(FILTER_ON_CYC);
  localparam logic [CNT_W-1:0] OFF_CYC = CNT_W'(FILTER_OFF_CYC);

  cal_state_t          cal_state_reg;
  logic                filt_init;
  logic [NUM_CHAN-1:0] first_comparator;
  logic [NUM_CHAN-1:0] second_comparator;
  logic [NUM_CHAN-1:0] filt_a;
  logic [NUM_CHAN-1:0] filt_b;
  logic [NUM_CHAN-1:0] sel_a;

  // ==========================================================
  // hysteresis decision: the choice of filter period and the next comparator state
  function automatic logic [CNT_W-1:0] filter_period(input logic en);
    filter_period = en ? ON_CYC : OFF_CYC;
  endfunction : filter_period

  // hold between the two trip points so noise near one point cannot chatter
  function automatic logic hyst_next(input comp_trip_t t, input logic cur);
    if (t.above_upper) begin
      hyst_next = 1'b1;
    end else if (!t.above_lower) begin
      hyst_next = 1'b0;
    end else begin
      hyst_next = cur;
    end
  endfunction : hyst_next

  // ==========================================================
  // calibration sequence after reset
  // filters are seeded only once the comparators have settled, so the
  // first value on the host status link is the true level, not a reset artefact
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_state_reg <= CAL_RUN;
    end else begin
      case (cal_state_reg)
        CAL_RUN: begin
          if (cal_ack) begin
            cal_state_reg <= CAL_FILT_INIT;
          end
        end
        CAL_FILT_INIT: begin
          cal_state_reg <= CAL_DONE;
        end
        CAL_DONE: begin
          cal_state_reg <= CAL_DONE;
        end
        default: begin
          cal_state_reg <= CAL_RUN;
        end
      endcase
    end
  end

  assign filt_init = (cal_state_reg == CAL_FILT_INIT);

  // calibration handshake outputs
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cal_request      <= 1'b1;
      calibration_done <= 1'b0;
    end else begin
      cal_request      <= (cal_state_reg == CAL_RUN) && !cal_ack;
      calibration_done <= (cal_state_reg != CAL_RUN);
    end
  end

  // ==========================================================
  // per channel comparators, filters and window selection
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      // comparator state with hysteresis
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          first_comparator[ch]  <= 1'b0;
          second_comparator[ch] <= 1'b0;
        end else begin
          first_comparator[ch]  <= hyst_next(trip_a[ch],
                                             first_comparator[ch]);
          second_comparator[ch] <= hyst_next(trip_b[ch],
                                             second_comparator[ch]);
        end
      end

      glitch_filter #(
        .CNT_W (CNT_W)
      ) u_filt_a (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .init     (filt_init),
        .raw      (first_comparator[ch]),
        .period   (filter_period(chan_cfg[ch].filter_en)),
        .filtered (filt_a[ch])
      );

      glitch_filter #(
        .CNT_W (CNT_W)
      ) u_filt_b (
        .clk_sys  (clk_sys),
        .rst_n    (rst_n),
        .init     (filt_init),
        .raw      (second_comparator[ch]),
        .period   (filter_period(chan_cfg[ch].filter_en)),
        .filtered (filt_b[ch])
      );

      // window result valid only if threshold a is above threshold b
      assign sel_a[ch] = chan_cfg[ch].window_mode ?
                         (filt_b[ch] & ~filt_a[ch]) :
                         filt_a[ch];

      // threshold references to the analog comparators
      always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
          thr_a_ref[ch*THR_W +: THR_W] <= THR_RESET;
          thr_b_ref[ch*THR_W +: THR_W] <= THR_RESET;
          zero_detect[ch]              <= 1'b0;
        end else begin
          thr_a_ref[ch*THR_W +: THR_W] <= chan_cfg[ch].thr_a;
          thr_b_ref[ch*THR_W +: THR_W] <= chan_cfg[ch].thr_b;
          // b at the 75 mV code and low: supply has decayed to ground
          zero_detect[ch] <= calibration_done &&
                             (chan_cfg[ch].thr_b == THR_ZERO_DETECT) &&
                             !filt_b[ch];
        end
      end
    end
  endgenerate

  // ==========================================================
  // host status link, gated until calibration completes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      link_status_a     <= '0;
      link_status_b     <= '0;
      link_status_valid <= 1'b0;
    end else if (calibration_done) begin
      link_status_a     <= sel_a;
      link_status_b     <= filt_b;
      link_status_valid <= 1'b1;
    end else begin
      link_status_a     <= '0;
      link_status_b     <= '0;
      link_status_valid <= 1'b0;
    end
  end

  // gpio control from the link is ignored until calibration completes
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_ctrl_out <= '0;
    end else if (calibration_done) begin
      gpio_ctrl_out <= gpio_ctrl_in;
    end
  end

  // ==========================================================
  // i2c readback and output control block feed
  // readback is not gated: software may watch the unseeded value early
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      i2c_status_a <= '0;
      i2c_status_b <= '0;
    end else begin
      i2c_status_a <= sel_a;
      i2c_status_b <= filt_b;
    end
  end

  // these two also bypass the link so local logic reacts without it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      channel4_a_status <= 1'b0;
      channel9_a_status <= 1'b0;
    end else begin
      channel4_a_status <= sel_a[CH4_IDX];
      channel9_a_status <= sel_a[CH9_IDX];
    end
  end

endmodule : voltage_monitor_status_logic

// ===== common/vmon_status_pkg.sv
// constants, types and timing counts for the voltage monitor status path
// assumes a single 40 MHz system clock and synchronous comparator inputs
package vmon_status_pkg;

  // ==========================================================
  // channel layout
  localparam int NUM_CH       = 10;  // nine standard plus one high voltage
  localparam int HV_CH_IDX    = 9;   // index of the high voltage channel
  localparam int CH4_IDX      = 3;   // channel 4, zero based
  localparam int CH9_IDX      = 8;   // channel 9, zero based

  // ==========================================================
  // threshold codes, 0.075 V (code 0) up to 5.734 V (code max)
  localparam int       THR_W         = 8;
  localparam int       THR_MIN_MV    = 75;
  localparam int       THR_MAX_MV    = 5734;
  localparam logic [7:0] THR_ZERO_DETECT = 8'h00;  // 75 mV setting
  localparam logic [7:0] THR_RESET       = 8'h00;

  // ==========================================================
  // timing
  localparam int CLK_HZ        = 40_000_000;
  localparam int FILTER_ON_US  = 64;
  localparam int FILTER_OFF_US = 16;
  localparam int CNT_W         = 12;
  localparam int FILTER_ON_CYC  = (FILTER_ON_US * (CLK_HZ / 1_000_000));
  localparam int FILTER_OFF_CYC = (FILTER_OFF_US * (CLK_HZ / 1_000_000));

  // ==========================================================
  // carriers
  typedef struct packed {
    logic             window_mode;  // 1: a output reports b and not a
    logic             filter_en;    // 1: 64 us filter, 0: 16 us path
    logic [THR_W-1:0] thr_a;
    logic [THR_W-1:0] thr_b;
  } chan_cfg_t;

  typedef struct packed {
    logic above_upper;  // input above the upper trip point
    logic above_lower;  // input above the lower trip point
  } comp_trip_t;

  typedef enum logic [1:0] {
    CAL_RUN,
    CAL_FILT_INIT,
    CAL_DONE
  } cal_state_t;

endpackage : vmon_status_pkg

// ===== design/glitch_filter.sv
// one stability counter filter for a single comparator output
// assumes raw is synchronous to clk_sys and period is at least one
`timescale 1ns/1ps
module glitch_filter #(
  parameter int CNT_W = 12
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             init,
  input  wire logic             raw,
  input  wire logic [CNT_W-1:0] period,
  output logic                  filtered
);

  logic [CNT_W-1:0] cnt_reg;

  // ==========================================================
  // stability counter
  // any return to the held value restarts the count, so a pulse shorter
  // than the period never reaches the output
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      filtered <= 1'b0;
      cnt_reg  <= '0;
    end else if (init) begin
      filtered <= raw;
      cnt_reg  <= '0;
    end else if (raw == filtered) begin
      cnt_reg  <= '0;
    end else if (cnt_reg >= period - 1'b1) begin
      filtered <= raw;
      cnt_reg  <= '0;
    end else begin
      cnt_reg  <= cnt_reg + 1'b1;
    end
  end

endmodule : glitch_filter

// ===== verification/vmon_status_properties.sv
// checker on the status path ports
// assumes it is bound onto the status logic top module
`timescale 1ns/1ps
module vmon_status_properties #(
  parameter int NUM_CHAN = 10,
  parameter int GPIO_W   = 9
) (
  input wire logic                clk_sys,
  input wire logic                rst_n,
  input wire logic                cal_ack,
  input wire logic [GPIO_W-1:0]   gpio_ctrl_in,
  input wire logic                calibration_done,
  input wire logic [NUM_CHAN-1:0] link_status_a,
  input wire logic [NUM_CHAN-1:0] link_status_b,
  input wire logic                link_status_valid,
  input wire logic [GPIO_W-1:0]   gpio_ctrl_out,
  input wire logic [NUM_CHAN-1:0] i2c_status_a,
  input wire logic                channel4_a_status,
  input wire logic                channel9_a_status
);
  import vmon_status_pkg::*;
  // ==========================================
  // one clock domain, so defaults are shared
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_gate;
    !calibration_done |-> !link_status_valid && (link_status_a == '0);
  endproperty
  a_gate: assert property (p_gate) else $error("early status");
  property p_gate_b;
    !calibration_done |-> link_status_b == '0;
  endproperty
  a_gate_b: assert property (p_gate_b) else $error("early b");
  property p_gpio_early;
    !calibration_done |-> gpio_ctrl_out == '0;
  endproperty
  a_gpio_early: assert property (p_gpio_early)
    else $error("gpio early");
  // done only follows an acknowledge two edges back
  property p_cal_rise;
    $rose(calibration_done) |-> $past(cal_ack, 2);
  endproperty
  a_cal_rise: assert property (p_cal_rise) else $error("done early");
  property p_sticky;
    calibration_done |=> calibration_done;
  endproperty
  a_sticky: assert property (p_sticky) else $error("done fell");
  property p_ocb;
    channel4_a_status == i2c_status_a[CH4_IDX];
  endproperty
  a_ocb: assert property (p_ocb) else $error("ch4 route");
  property p_ocb9;
    channel9_a_status == i2c_status_a[CH9_IDX];
  endproperty
  a_ocb9: assert property (p_ocb9) else $error("ch9 route");
  property p_gpio_take;
    calibration_done |=> gpio_ctrl_out == $past(gpio_ctrl_in);
  endproperty
  a_gpio_take: assert property (p_gpio_take) else $error("gpio lost");
endmodule : vmon_status_properties

bind voltage_monitor_status_logic vmon_status_properties #(
  .NUM_CHAN(NUM_CHAN), .GPIO_W(GPIO_W)) u_chk (
  .clk_sys(clk_sys), .rst_n(rst_n), .cal_ack(cal_ack),
  .gpio_ctrl_in(gpio_ctrl_in), .calibration_done(calibration_done),
  .link_status_a(link_status_a), .link_status_b(link_status_b),
  .link_status_valid(link_status_valid), .gpio_ctrl_out(gpio_ctrl_out),
  .i2c_status_a(i2c_status_a), .channel4_a_status(channel4_a_status),
  .channel9_a_status(channel9_a_status));

// ===== verification/mgmt_ctrl_model.sv
// model of the management controller on the host link
// assumes window and filter choices come from the bench
`timescale 1ns/1ps
module mgmt_ctrl_model (
  input  wire logic                       clk_sys,
  input  wire logic [9:0]                 win,
  input  wire logic [9:0]                 filt,
  input  wire logic [9:0]                 link_status_a,
  input  wire logic                       link_status_valid,
  output vmon_status_pkg::chan_cfg_t [9:0] chan_cfg,
  output logic [9:0]                      rx_a
);
  import vmon_status_pkg::*;
  // ==========================================
  // a above b keeps the window result meaningful
  // channel index 7 sits at the zero detect code so that flag is exercised
  always_comb begin
    for (int i = 0; i < 10; i++) begin
      chan_cfg[i] = {win[i], filt[i], 8'hC0,
                     (i == 7) ? 8'h00 : 8'h40};
    end
  end
  // status is only believed while flagged valid
  always_ff @(posedge clk_sys) begin
    if (link_status_valid) rx_a <= link_status_a;
  end
endmodule : mgmt_ctrl_model

// ===== verification/tb_top.sv
// self checking bench for the monitor status path
// assumes a 40 MHz clock and the controller model
`timescale 1ns/1ps
module tb_top;
  import vmon_status_pkg::*;
  logic clk_sys = 1'b0, rst_n = 1'b0, cal_ack = 1'b0;
  logic [8:0] gpio_in = 9'h000, gpio_out;
  logic [9:0] win = 10'h000, filt = 10'h000;
  comp_trip_t [9:0] trip_a = '0, trip_b = '0;
  chan_cfg_t [9:0] cfg;
  logic done, valid, ch4, ch9, cal_req;
  logic [9:0] lk_a, lk_b, i2_a, i2_b, rx_a, zd;
  logic [79:0] ref_a, ref_b;
  int n_errors = 0, checks = 0, cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  // ==========================================
  voltage_monitor_status_logic DUT (.clk_sys(clk_sys), .rst_n(rst_n),
    .chan_cfg(cfg), .trip_a(trip_a), .trip_b(trip_b), .cal_ack(cal_ack),
    .gpio_ctrl_in(gpio_in), .cal_request(cal_req), .calibration_done(done),
    .link_status_a(lk_a), .link_status_b(lk_b), .link_status_valid(valid),
    .gpio_ctrl_out(gpio_out), .i2c_status_a(i2_a), .i2c_status_b(i2_b),
    .zero_detect(zd), .thr_a_ref(ref_a), .thr_b_ref(ref_b),
    .channel4_a_status(ch4), .channel9_a_status(ch9));
  mgmt_ctrl_model u_ctrl (.clk_sys(clk_sys), .win(win), .filt(filt),
    .link_status_a(lk_a), .link_status_valid(valid), .chan_cfg(cfg),
    .rx_a(rx_a));
  // hang guard, runs well past the longest sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 25000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic chk(input string nm, input logic [9:0] e,
                     input logic [9:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // inputs move 2 ns after the edge, clear of sampling
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : wt
  task automatic t_cal;
    gpio_in = 9'h155;
    trip_b[5] = 2'b11;
    // only the lower trip point: the comparator must stay low
    trip_b[6] = 2'b01;
    wt(6);
    chk("done", 10'h000, {9'h0, done});
    chk("gpio", 10'h000, {1'b0, gpio_out});
    chk("link_b", 10'h000, lk_b);
    chk("cal_req", 10'h001, {9'h0, cal_req});
    chk("zd", 10'h000, zd);
    cal_ack = 1'b1;
    wt(6);
    chk("done", 10'h001, {9'h0, valid & done});
    chk("link_b", 10'h020, lk_b);
    chk("gpio", 10'h155, {1'b0, gpio_out});
    chk("cal_req", 10'h000, {9'h0, cal_req});
    chk("zd", 10'h080, zd);
    chk("ref_a0", 10'h0C0, {2'b00, ref_a[7:0]});
    chk("ref_b0", 10'h040, {2'b00, ref_b[7:0]});
    $display("t_cal done");
  endtask : t_cal
  // ch0 filtered, ch1 on the short path
  task automatic t_filt;
    filt = 10'h001;
    trip_b[0] = 2'b11;
    trip_b[1] = 2'b11;
    trip_b[7] = 2'b11;
    wt(600);
    chk("b01", 10'h000, {8'h0, i2_b[1:0]});
    wt(60);
    chk("b01", 10'h002, {8'h0, i2_b[1:0]});
    chk("zd", 10'h000, zd);
    wt(1880);
    chk("b01", 10'h002, {8'h0, lk_b[1:0]});
    wt(40);
    chk("b01", 10'h003, {8'h0, lk_b[1:0]});
    trip_b[0] = 2'b01;
    wt(2600);
    chk("hold", 10'h003, {8'h0, i2_b[1:0]});
    trip_b[0] = 2'b00;
    wt(2000);
    trip_b[0] = 2'b11;
    wt(2700);
    chk("glitch", 10'h003, {8'h0, i2_b[1:0]});
    trip_b[0] = 2'b00;
    wt(2600);
    chk("fall", 10'h002, {8'h0, i2_b[1:0]});
    $display("t_filt done");
  endtask : t_filt
  // ch3 in window mode, ch8 raw, both fast path
  task automatic t_win;
    win = 10'h008;
    wt(700);
    chk("a48", 10'h000, {8'h0, ch9, ch4});
    trip_b[3] = 2'b11;
    trip_b[8] = 2'b11;
    wt(700);
    chk("a48", 10'h001, {8'h0, ch9, ch4});
    chk("b38", 10'h108, i2_b & 10'h108);
    chk("lk_a", 10'h008, lk_a & 10'h108);
    trip_a[3] = 2'b11;
    trip_a[8] = 2'b11;
    wt(700);
    chk("a48", 10'h002, {8'h0, ch9, ch4});
    chk("rx_a", 10'h100, rx_a & 10'h108);
    chk("i2_a", 10'h100, i2_a & 10'h108);
    $display("t_win done");
  endtask : t_win
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done
  initial begin
    repeat (20) @(posedge clk_sys);
    #2 rst_n = 1'b1;
    t_cal();
    t_filt();
    t_win();
    test_done();
  end
endmodule : tb_top
